/* File: rtl/rcrb_top.sv */
`timescale 1ns/1ns
// ==========================================
// radio configuration register bank behind a serial port
module rcrb_top
    import rcrb_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // serial port pins (mode 0, msb first)
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    // radio mode
    input wire logic tx_mode,
    // external low-frequency clock pin and internal rc clock
    input wire logic gpio_lf_clk,
    input wire logic internal_rc_clk,
    output logic lf_clk_out,
    output logic external_rc_clock_select,
    // packet control field bytes
    output logic [7:0] tx_control_field_3,
    output logic [7:0] tx_control_field_2,
    output logic [7:0] tx_control_field_1,
    output logic [7:0] tx_control_field_0,
    // synthesizer
    input wire logic [31:0] synth_base_freq,
    input wire logic [23:0] channel_spacing,
    output logic [7:0] channel_index_value,
    output logic [31:0] carrier_freq,
    // power management
    output logic temp_sensor_buffer_enable,
    output logic regulator_enable,
    output logic regulator_off,
    output logic regulator_tune_voltage_sel,
    output logic regulator_bandwidth_sel,
    output logic rate_multiplier_select,
    output logic [14:0] rate_multiplier_divider,
    input wire logic [31:0] oscillator_frequency,
    output logic [31:0] regulator_switch_freq,
    // calibration
    output logic [3:0] rc_osc_trim_word,
    output logic [4:0] rc_osc_feedback_word,
    output logic [6:0] vco_cal_word_transmit,
    output logic [6:0] vco_cal_word_receive,
    output logic [6:0] vco_cal_applied,
    output logic [5:0] vco_bias_current,
    // cipher
    output logic [7:0] cipher_key_top_byte
);
    // maps an offset to a register index; valid flags a hit
    function automatic logic [IDX_W:0] rcrb_decode(input logic [7:0] addr);
        case (addr)
            ADDR_TX_CTRL_3: rcrb_decode = 5'h10;
            ADDR_TX_CTRL_2: rcrb_decode = 5'h11;
            ADDR_TX_CTRL_1: rcrb_decode = 5'h12;
            ADDR_TX_CTRL_0: rcrb_decode = 5'h13;
            ADDR_CHANNEL: rcrb_decode = 5'h14;
            ADDR_OSC_CAL_2: rcrb_decode = 5'h15;
            ADDR_OSC_CAL_1: rcrb_decode = 5'h16;
            ADDR_OSC_CAL_0: rcrb_decode = 5'h17;
            ADDR_KEY_15: rcrb_decode = 5'h18;
            ADDR_VCO_BIAS: rcrb_decode = 5'h19;
            ADDR_PWR_2: rcrb_decode = 5'h1A;
            ADDR_PWR_1: rcrb_decode = 5'h1B;
            ADDR_PWR_0: rcrb_decode = 5'h1C;
            ADDR_OSC_SRC: rcrb_decode = 5'h1D;
            ADDR_TEST_SEL: rcrb_decode = 5'h1E;
            ADDR_PWR_TEST: rcrb_decode = 5'h1F;
            default: rcrb_decode = 5'h00;
        endcase
    endfunction : rcrb_decode

    // ==========================================
    // pin synchronisers
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic [1:0] lf_sync;
    logic [1:0] rc_sync;
    logic sclk_prev;

    // two flops per pin; only the second stage is read
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            mosi_sync <= 2'h0;
            lf_sync <= 2'h0;
            rc_sync <= 2'h0;
            sclk_prev <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], spi_sclk};
            cs_sync <= {cs_sync[0], spi_cs_n};
            mosi_sync <= {mosi_sync[0], spi_mosi};
            lf_sync <= {lf_sync[0], gpio_lf_clk};
            rc_sync <= {rc_sync[0], internal_rc_clk}; // rc clock is another domain
            sclk_prev <= sclk_sync[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;
    assign sclk_rise = sclk_sync[1] & ~sclk_prev;
    assign sclk_fall = ~sclk_sync[1] & sclk_prev;
    assign cs_active = ~cs_sync[1];

    // ==========================================
    // serial frame: command byte, address byte, then data bytes
    rcrb_state_t state;
    rcrb_state_t next_state;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] next_shift_in;
    logic [7:0] addr;
    logic [7:0] next_addr;
    logic is_read;
    logic next_is_read;
    logic [7:0] shift_out;
    logic [7:0] next_shift_out;
    logic load_pending;
    logic next_load_pending;
    logic wr_en;
    logic [7:0] wr_data;
    logic [IDX_W:0] hit;
    logic [7:0] rd_data;
    logic [REG_COUNT*8-1:0] contents;
    logic [7:0] in_byte;

    assign in_byte = {shift_in[6:0], mosi_sync[1]};
    assign hit = rcrb_decode(addr);

    // frame sequencing; address auto-increments over a burst
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_addr = addr;
        next_is_read = is_read;
        next_shift_out = shift_out;
        next_load_pending = 1'b0;
        wr_en = 1'b0;
        wr_data = in_byte;
        if (!cs_active) begin
            next_state = RCRB_IDLE;
            next_bit_cnt = 3'h0;
        end else begin
            case (state)
                RCRB_IDLE: begin
                    next_state = RCRB_CMD;
                    next_bit_cnt = 3'h0;
                end
                RCRB_CMD, RCRB_ADDR, RCRB_DATA: begin
                    if (sclk_rise) begin
                        next_shift_in = in_byte;
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            if (state == RCRB_CMD) begin
                                next_is_read = in_byte[CMD_READ_BIT];
                                next_state = RCRB_ADDR;
                            end else if (state == RCRB_ADDR) begin
                                next_addr = in_byte;
                                next_state = RCRB_DATA;
                                next_load_pending = 1'b1;
                            end else begin
                                // unmapped offsets drop writes, read zero
                                wr_en = ~is_read & hit[IDX_W];
                                next_addr = addr + 8'h01;
                                next_load_pending = 1'b1;
                            end
                        end
                    end
                    if (sclk_fall && state == RCRB_DATA && bit_cnt != 3'h0) begin
                        next_shift_out = {shift_out[6:0], 1'b0};
                    end
                    if (load_pending) begin
                        next_shift_out = 8'h00;
                    end
                end
                default: next_state = RCRB_IDLE;
            endcase
        end
    end

    // read data comes one cycle after the index; capture it then
    logic load_now;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= RCRB_IDLE;
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
            addr <= 8'h00;
            is_read <= 1'b0;
            shift_out <= 8'h00;
            load_pending <= 1'b0;
            load_now <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            addr <= next_addr;
            is_read <= next_is_read;
            load_pending <= next_load_pending;
            load_now <= load_pending;
            if (load_now) begin
                shift_out <= hit[IDX_W] ? rd_data : 8'h00;
            end else begin
                shift_out <= next_shift_out;
            end
        end
    end

    rcrb_regfile u_regs (
        .core_clk(core_clk),
        .reset(reset),
        .wr_en(wr_en),
        .wr_idx(hit[IDX_W-1:0]),
        .wr_data(wr_data),
        .rd_idx(hit[IDX_W-1:0]),
        .rd_data(rd_data),
        .contents(contents)
    );

    // ==========================================
    // field decode from stored bytes
    logic [7:0] r_pwr2;
    logic [7:0] r_pwr1;
    logic [7:0] r_pwr0;
    logic [7:0] r_cal2;
    logic [7:0] r_cal1;
    logic [7:0] r_cal0;
    logic [14:0] divider;
    logic [46:0] rm_product;
    assign r_cal2 = contents[5*8 +: 8];
    assign r_cal1 = contents[6*8 +: 8];
    assign r_cal0 = contents[7*8 +: 8];
    assign r_pwr2 = contents[10*8 +: 8];
    assign r_pwr1 = contents[11*8 +: 8];
    assign r_pwr0 = contents[12*8 +: 8];
    assign divider = {r_pwr1[6:0], r_pwr0};
    assign rm_product = 47'(oscillator_frequency) * 47'(divider);

    // every output registered; datapath products are long, so one cycle of latency
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_control_field_3 <= RST_TX_CTRL;
            tx_control_field_2 <= RST_TX_CTRL;
            tx_control_field_1 <= RST_TX_CTRL;
            tx_control_field_0 <= RST_TX_CTRL;
            channel_index_value <= RST_CHANNEL;
            carrier_freq <= 32'h0000_0000;
            // decoded fields reset to the stored reset bytes, so they do not jump on release; regulator_switch_freq and carrier_freq reset to zero
            temp_sensor_buffer_enable <= RST_PWR_2[BIT_TS_BUFFER];
            regulator_off <= RST_PWR_2[BIT_REG_OFF];
            regulator_enable <= ~RST_PWR_2[BIT_REG_OFF];
            regulator_tune_voltage_sel <= RST_PWR_2[BIT_VTUNE];
            regulator_bandwidth_sel <= RST_PWR_2[BIT_PLLBW];
            rate_multiplier_select <= RST_PWR_1[BIT_RM_SEL];
            rate_multiplier_divider <= {RST_PWR_1[6:0], RST_PWR_0};
            regulator_switch_freq <= 32'h0000_0000;
            rc_osc_trim_word <= RST_OSC_CAL_2[7:4];
            rc_osc_feedback_word <= {RST_OSC_CAL_2[3:0], RST_OSC_CAL_1[BIT_RFB_LOW]};
            vco_cal_word_transmit <= RST_OSC_CAL_1[6:0];
            vco_cal_word_receive <= RST_OSC_CAL_0[6:0];
            vco_cal_applied <= RST_OSC_CAL_0[6:0];
            vco_bias_current <= RST_VCO_BIAS[5:0];
            cipher_key_top_byte <= RST_KEY_15;
            external_rc_clock_select <= RST_OSC_SRC[BIT_EXT_RC];
            lf_clk_out <= 1'b0;
            spi_miso <= 1'b0;
        end else begin
            tx_control_field_3 <= contents[0*8 +: 8];
            tx_control_field_2 <= contents[1*8 +: 8];
            tx_control_field_1 <= contents[2*8 +: 8];
            tx_control_field_0 <= contents[3*8 +: 8];
            channel_index_value <= contents[4*8 +: 8];
            carrier_freq <= synth_base_freq
                + 32'(contents[4*8 +: 8] * channel_spacing);
            temp_sensor_buffer_enable <= r_pwr2[BIT_TS_BUFFER];
            regulator_off <= r_pwr2[BIT_REG_OFF];
            regulator_enable <= ~r_pwr2[BIT_REG_OFF];
            regulator_tune_voltage_sel <= r_pwr2[BIT_VTUNE];
            regulator_bandwidth_sel <= r_pwr2[BIT_PLLBW];
            rate_multiplier_select <= r_pwr1[BIT_RM_SEL];
            rate_multiplier_divider <= divider;
            if (r_pwr1[BIT_RM_SEL]) begin
                regulator_switch_freq <= 32'(rm_product >> RM_FRAC_BITS);
            end else begin
                regulator_switch_freq <= oscillator_frequency >> FIXED_DIV_LOG2;
            end
            rc_osc_trim_word <= r_cal2[7:4];
            rc_osc_feedback_word <= {r_cal2[3:0], r_cal1[BIT_RFB_LOW]};
            vco_cal_word_transmit <= r_cal1[6:0];
            vco_cal_word_receive <= r_cal0[6:0];
            vco_cal_applied <= tx_mode ? r_cal1[6:0] : r_cal0[6:0];
            vco_bias_current <= contents[9*8 +: 6];
            cipher_key_top_byte <= contents[8*8 +: 8];
            external_rc_clock_select <= contents[13*8 + BIT_EXT_RC];
            // low-frequency clock source mux
            lf_clk_out <= contents[13*8 + BIT_EXT_RC] ? lf_sync[1] : rc_sync[1];
            spi_miso <= (state == RCRB_DATA && is_read) ? shift_out[7] : 1'b0;
        end
    end
endmodule : rcrb_top

/* File: rtl/rcrb_pkg.sv */
package rcrb_pkg;
    // ==========================================
    // register offsets
    localparam logic [7:0] ADDR_TX_CTRL_3 = 8'h68;
    localparam logic [7:0] ADDR_TX_CTRL_2 = 8'h69;
    localparam logic [7:0] ADDR_TX_CTRL_1 = 8'h6A;
    localparam logic [7:0] ADDR_TX_CTRL_0 = 8'h6B;
    localparam logic [7:0] ADDR_CHANNEL = 8'h6C;
    localparam logic [7:0] ADDR_OSC_CAL_2 = 8'h6D;
    localparam logic [7:0] ADDR_OSC_CAL_1 = 8'h6E;
    localparam logic [7:0] ADDR_OSC_CAL_0 = 8'h6F;
    localparam logic [7:0] ADDR_KEY_15 = 8'h70;
    localparam logic [7:0] ADDR_VCO_BIAS = 8'hA1;
    localparam logic [7:0] ADDR_PWR_2 = 8'hA4;
    localparam logic [7:0] ADDR_PWR_1 = 8'hA5;
    localparam logic [7:0] ADDR_PWR_0 = 8'hA6;
    localparam logic [7:0] ADDR_OSC_SRC = 8'hA7;
    localparam logic [7:0] ADDR_TEST_SEL = 8'hA8;
    localparam logic [7:0] ADDR_PWR_TEST = 8'hB2;
    // ==========================================
    // reset values
    localparam logic [7:0] RST_TX_CTRL = 8'h00;
    localparam logic [7:0] RST_CHANNEL = 8'h00;
    localparam logic [7:0] RST_OSC_CAL_2 = 8'h70;
    localparam logic [7:0] RST_OSC_CAL_1 = 8'h48;
    localparam logic [7:0] RST_OSC_CAL_0 = 8'h48;
    localparam logic [7:0] RST_KEY_15 = 8'h00;
    localparam logic [7:0] RST_VCO_BIAS = 8'h11;
    localparam logic [7:0] RST_PWR_2 = 8'h0C;
    localparam logic [7:0] RST_PWR_1 = 8'h20;
    localparam logic [7:0] RST_PWR_0 = 8'h00;
    localparam logic [7:0] RST_OSC_SRC = 8'hE1;
    localparam logic [7:0] RST_TEST_SEL = 8'h00;
    localparam logic [7:0] RST_PWR_TEST = 8'h42;
    // ==========================================
    // field positions
    localparam int BIT_TS_BUFFER = 6;
    localparam int BIT_REG_OFF = 5;
    localparam int BIT_VTUNE = 3;
    localparam int BIT_PLLBW = 2;
    localparam int BIT_RM_SEL = 7;
    localparam int BIT_EXT_RC = 3;
    localparam int BIT_RFB_LOW = 7;
    localparam int RM_FRAC_BITS = 15;
    localparam logic [1:0] FIXED_DIV_LOG2 = 2'h2;
    // register file depth and index width
    localparam int REG_COUNT = 16;
    localparam int IDX_W = 4;
    // ==========================================
    // serial port command byte: bit seven set means read
    localparam int CMD_READ_BIT = 7;
    // serial port frame states
    typedef enum logic [1:0] {
        RCRB_IDLE = 2'b00,
        RCRB_CMD = 2'b01,
        RCRB_ADDR = 2'b11,
        RCRB_DATA = 2'b10
    } rcrb_state_t;
    // per-register reset table, same order as offsets
    function automatic logic [7:0] rcrb_reset_of(input logic [IDX_W-1:0] idx);
        case (idx)
            4'h4: rcrb_reset_of = RST_CHANNEL;
            4'h5: rcrb_reset_of = RST_OSC_CAL_2;
            4'h6: rcrb_reset_of = RST_OSC_CAL_1;
            4'h7: rcrb_reset_of = RST_OSC_CAL_0;
            4'h8: rcrb_reset_of = RST_KEY_15;
            4'h9: rcrb_reset_of = RST_VCO_BIAS;
            4'hA: rcrb_reset_of = RST_PWR_2;
            4'hB: rcrb_reset_of = RST_PWR_1;
            4'hC: rcrb_reset_of = RST_PWR_0;
            4'hD: rcrb_reset_of = RST_OSC_SRC;
            4'hE: rcrb_reset_of = RST_TEST_SEL;
            4'hF: rcrb_reset_of = RST_PWR_TEST;
            default: rcrb_reset_of = RST_TX_CTRL;
        endcase
    endfunction : rcrb_reset_of
endpackage : rcrb_pkg

/* File: rtl/rcrb_regfile.sv */
`timescale 1ns/1ns
// ==========================================
// register storage, registered read data
module rcrb_regfile
    import rcrb_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // write port
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    // read port
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [7:0] rd_data,
    // all contents flattened, for the control decode
    output logic [REG_COUNT*8-1:0] contents
);
    logic [7:0] mem [REG_COUNT];
    logic [7:0] next_mem [REG_COUNT];
    logic [7:0] next_rd_data;

    // next contents: write replaces one byte
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            next_mem[i] = mem[i];
        end
        if (wr_en) begin
            next_mem[wr_idx] = wr_data;
        end
        next_rd_data = mem[rd_idx];
    end

    // storage, reset per register to its own value
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < REG_COUNT; i++) begin
            if (reset) begin
                mem[i] <= rcrb_reset_of(IDX_W'(i));
            end else begin
                mem[i] <= next_mem[i];
            end
        end
        rd_data <= reset ? 8'h00 : next_rd_data;
    end

    // flatten for the main module
    genvar g;
    generate
        for (g = 0; g < REG_COUNT; g++) begin : g_flat
            assign contents[g*8 +: 8] = mem[g];
        end
    endgenerate
endmodule : rcrb_regfile

/* File: bench/rcrb_properties.sv */
`timescale 1ns/1ns
// ==========================================
// port-level checks for the register bank
module rcrb_checker
    import rcrb_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // radio mode and low-frequency clocks
    input wire logic tx_mode,
    input wire logic gpio_lf_clk,
    input wire logic internal_rc_clk,
    input wire logic lf_clk_out,
    input wire logic external_rc_clock_select,
    // synthesizer
    input wire logic [31:0] synth_base_freq,
    input wire logic [23:0] channel_spacing,
    input wire logic [7:0] channel_index_value,
    input wire logic [31:0] carrier_freq,
    // power management
    input wire logic regulator_enable,
    input wire logic regulator_off,
    input wire logic rate_multiplier_select,
    input wire logic [14:0] rate_multiplier_divider,
    input wire logic [31:0] oscillator_frequency,
    input wire logic [31:0] regulator_switch_freq,
    // calibration
    input wire logic [6:0] vco_cal_word_transmit,
    input wire logic [6:0] vco_cal_word_receive,
    input wire logic [6:0] vco_cal_applied
);
    // settle count: derived outputs lag reset release by a cycle or two
    logic [1:0] settle;
    logic [1:0] next_settle;
    logic ok;
    always_comb begin
        next_settle = (settle == 2'h3) ? settle : settle + 2'h1;
        ok = (settle == 2'h3);
    end
    always_ff @(posedge core_clk) begin
        settle <= reset ? 2'h0 : next_settle;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // ==========================================
    // assertions
    chk_regulator_on_inverse: assert property (ok |-> regulator_enable == !regulator_off)
        else $error("regulator enable is not the inverse of off");
    chk_vco_tx_pick: assert property (ok && tx_mode && $past(tx_mode)
        && $stable(vco_cal_word_transmit) |-> vco_cal_applied == vco_cal_word_transmit)
        else $error("transmit vco word not applied");
    chk_vco_rx_pick: assert property (ok && !tx_mode && !$past(tx_mode)
        && $stable(vco_cal_word_receive) |-> vco_cal_applied == vco_cal_word_receive)
        else $error("receive vco word not applied");
    chk_fsw_fixed_div: assert property (ok && !rate_multiplier_select
        && $past(oscillator_frequency, 2) == oscillator_frequency
        |-> regulator_switch_freq == oscillator_frequency >> 2)
        else $error("switching frequency not oscillator over four");
    chk_fsw_rate_mult: assert property (ok && rate_multiplier_select
        && $stable(rate_multiplier_divider) && $past(oscillator_frequency, 2) == oscillator_frequency
        |-> regulator_switch_freq
        == 32'((48'(oscillator_frequency) * 48'(rate_multiplier_divider)) >> 15))
        else $error("switching frequency not from rate multiplier");
    chk_carrier_sum: assert property (ok && $stable(channel_index_value)
        && $past(synth_base_freq, 2) == synth_base_freq && $past(channel_spacing, 2) == channel_spacing
        |-> carrier_freq == synth_base_freq + 32'(channel_index_value) * 32'(channel_spacing))
        else $error("carrier frequency wrong");
    chk_lf_internal_src: assert property (ok && !external_rc_clock_select
        && $stable(external_rc_clock_select) |-> lf_clk_out == $past(internal_rc_clk, 3))
        else $error("internal rc clock not passed through");
    chk_lf_ext_rise: assert property (ok && external_rc_clock_select && $rose(gpio_lf_clk)
        |-> ##[2:4] lf_clk_out)
        else $error("external clock rise not passed through");
    chk_lf_ext_fall: assert property (ok && external_rc_clock_select && $fell(gpio_lf_clk)
        |-> ##[2:4] !lf_clk_out)
        else $error("external clock fall not passed through");
    // main scenarios reached
    cov_tx_rate_mult: cover property (tx_mode && rate_multiplier_select);
    cov_ext_clock: cover property (external_rc_clock_select && lf_clk_out);
    cov_regulator_off: cover property (regulator_off);
endmodule : rcrb_checker

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
// ==========================================
// self-checking bench for the register bank
module tb_top import rcrb_pkg::*;;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic spi_sclk = 1'b0, spi_cs_n = 1'b1, spi_mosi = 1'b0, tx_mode = 1'b0;
    logic gpio_lf_clk = 1'b0, internal_rc_clk = 1'b0;
    logic [31:0] synth_base_freq = 32'h0, oscillator_frequency = 32'h0;
    logic [23:0] channel_spacing = 24'h0;
    wire spi_miso, lf_clk_out, external_rc_clock_select, temp_sensor_buffer_enable;
    wire regulator_enable, regulator_off, regulator_tune_voltage_sel;
    wire regulator_bandwidth_sel, rate_multiplier_select;
    wire [7:0] tx_control_field_3, tx_control_field_2, tx_control_field_1;
    wire [7:0] tx_control_field_0, channel_index_value, cipher_key_top_byte;
    wire [14:0] rate_multiplier_divider;
    wire [31:0] carrier_freq, regulator_switch_freq;
    wire [3:0] rc_osc_trim_word;
    wire [4:0] rc_osc_feedback_word;
    wire [6:0] vco_cal_word_transmit, vco_cal_word_receive, vco_cal_applied;
    wire [5:0] vco_bias_current;
    int error_cnt = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h0F09BB69;
    logic [7:0] sh [16];
    localparam logic [7:0] ADDR_TAB [16] = '{8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D,
        8'h6E, 8'h6F, 8'h70, 8'hA1, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hB2};
    localparam logic [7:0] RST_TAB [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h70,
        8'h48, 8'h48, 8'h00, 8'h11, 8'h0C, 8'h20, 8'h00, 8'hE1, 8'h00, 8'h42};

    rcrb_top dut_u (.*);

    always #4 core_clk = ~core_clk;
    // rc clock toggles every seven cycles; slow pin toggles at roughly 34.7 kHz
    always begin
        repeat (7) @(negedge core_clk);
        internal_rc_clk = ~internal_rc_clk;
    end
    always begin
        repeat (1801) @(negedge core_clk);
        gpio_lf_clk = ~gpio_lf_clk;
    end
    // ==========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // reserved fields forced to their reset levels
    function automatic logic [7:0] legal(input int i, input logic [7:0] v);
        case (i)
            7: return v & 8'h7F;
            9: return v & 8'h3F;
            10: return v & 8'h6C;
            13: return (v & 8'h08) | 8'hE1;
            default: return v;
        endcase
    endfunction : legal
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    // sclk kept at a tenth of core rate, well under the eighth allowed
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            cyc(5);
            rx[i] = spi_miso;
            spi_sclk = 1'b1;
            cyc(5);
            spi_sclk = 1'b0;
        end
    endtask : xfer
    task automatic frame(input logic [7:0] cmd, input logic [7:0] adr, inout logic [7:0] dat);
        logic [7:0] junk;
        spi_cs_n = 1'b0;
        cyc(3);
        xfer(cmd, junk);
        xfer(adr, junk);
        xfer(dat, dat);
        cyc(3);
        spi_cs_n = 1'b1;
        cyc(10);
    endtask : frame
    task automatic wr(input logic [7:0] adr, input logic [7:0] val);
        logic [7:0] t;
        t = val;
        frame(8'h00, adr, t);
    endtask : wr
    task automatic rd(input logic [7:0] adr, output logic [7:0] val);
        val = 8'h00;
        frame(8'h80, adr, val);
    endtask : rd
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // decoded outputs against the shadow copy
    task automatic check_outs();
        chk("tx_fields", {sh[0], sh[1], sh[2], sh[3]}, {tx_control_field_3,
            tx_control_field_2, tx_control_field_1, tx_control_field_0});
        chk("channel", sh[4], channel_index_value);
        chk("carrier", 32'(synth_base_freq + 32'(sh[4]) * 32'(channel_spacing)), carrier_freq);
        chk("temp_buf", sh[10][6], temp_sensor_buffer_enable);
        chk("regulator", {sh[10][5], !sh[10][5]}, {regulator_off, regulator_enable});
        chk("tune_bw", sh[10][3:2], {regulator_tune_voltage_sel, regulator_bandwidth_sel});
        chk("divider", {sh[11], sh[12]}, {rate_multiplier_select, rate_multiplier_divider});
        chk("fsw", sh[11][7] ? 32'((48'(oscillator_frequency) * {sh[11][6:0], sh[12]}) >> 15)
            : oscillator_frequency >> 2, regulator_switch_freq);
        chk("rc_words", {sh[5], sh[6][7]}, {rc_osc_trim_word, rc_osc_feedback_word});
        chk("vco", {sh[6][6:0], sh[7][6:0], tx_mode ? sh[6][6:0] : sh[7][6:0]},
            {vco_cal_word_transmit, vco_cal_word_receive, vco_cal_applied});
        chk("key_top", sh[8], cipher_key_top_byte);
        chk("bias", sh[9][5:0], vco_bias_current);
        chk("ext_sel", sh[13][3], external_rc_clock_select);
    endtask : check_outs
    task automatic complete_run();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // ==========================================
    // main sequence
    initial begin
        logic [7:0] d;
        cyc(20);
        reset = 1'b0;
        cyc(4);
        for (int i = 0; i < 16; i++) begin
            rd(ADDR_TAB[i], d);
            chk("reset_val", RST_TAB[i], d);
            sh[i] = RST_TAB[i];
        end
        check_outs();
        // unmapped place drops the write and reads zero
        wr(8'h71, 8'h5A);
        rd(8'h71, d);
        chk("unmapped", 8'h00, d);
        // test registers never touched, reserved bits kept at reset level
        for (int r = 0; r < 6; r++) begin
            synth_base_freq = rnd();
            channel_spacing = 24'(rnd());
            oscillator_frequency = rnd();
            tx_mode = oscillator_frequency[5];
            for (int i = 0; i < 14; i++) begin
                sh[i] = legal(i, 8'(rnd()));
                if (r < 2 && (i == 11 || i == 12)) sh[i] = (r == 0) ? 8'hFF : 8'h00;
                wr(ADDR_TAB[i], sh[i]);
            end
            for (int i = 0; i < 14; i++) begin
                rd(ADDR_TAB[i], d);
                chk("readback", sh[i], d);
            end
            check_outs();
        end
        // burst read walks the four control bytes by auto-increment
        spi_cs_n = 1'b0;
        cyc(3);
        xfer(8'h80, d);
        xfer(ADDR_TAB[0], d);
        for (int i = 0; i < 4; i++) begin
            xfer(8'h00, d);
            chk("burst", sh[i], d);
        end
        cyc(3);
        spi_cs_n = 1'b1;
        cyc(10);
        // external slow clock selected across a full pin period
        sh[13] = 8'hE9;
        wr(ADDR_TAB[13], sh[13]);
        cyc(4000);
        check_outs();
        complete_run();
    end
    initial begin
        repeat (100000) @(negedge core_clk);
        error_cnt++;
        complete_run();
    end
endmodule : tb_top

bind rcrb_top rcrb_checker chk_u (.*);
